// File: dv/lcc_cluster_props.sv
`timescale 1ns/1ns
module lcc_cluster_props #(
   parameter logic [9:0] POWERUP_HIGH = '0
) (
   input wire logic        clock_i,             // cluster clock
   input wire logic        rstn_i,              // sync reset, low
   input wire logic        s_axi_awvalid_i,     // aw valid
   input wire logic        s_axi_awready_o,     // aw ready
   input wire logic        s_axi_wvalid_i,      // w valid
   input wire logic        s_axi_wready_o,      // w ready
   input wire logic [1:0]  s_axi_bresp_o,       // b code
   input wire logic        s_axi_bvalid_o,      // b valid
   input wire logic        s_axi_bready_i,      // b ready
   input wire logic        s_axi_arvalid_i,     // ar valid
   input wire logic        s_axi_arready_o,     // ar ready
   input wire logic [31:0] s_axi_rdata_o,       // r data
   input wire logic        s_axi_rvalid_o,      // r valid
   input wire logic        s_axi_rready_i,      // r ready
   input wire logic        chip_wide_clear_n_i, // clear pin
   input wire logic [9:0]  comb_o,              // unregistered
   input wire logic [9:0]  reg_o,               // registered
   input wire logic        reg_chain_o,         // reg chain out
   input wire logic        lut_chain_o,         // lut chain out
   input wire logic        chip_clear_gpio_o    // pin as io
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> s_axi_bvalid_o) else $error("write answer late");
   a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write answer dropped");
   a_write_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken while answering");
   a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read answer dropped");
   a_chain_taps: assert property (reg_chain_o == reg_o[9] && lut_chain_o == comb_o[9])
      else $error("chain outputs differ from last cell");
   // three low samples pass the two sync stages, then the clear lands
   a_chip_clear: assert property (!chip_wide_clear_n_i [*3] |=> reg_o == 10'h000)
      else $error("chip clear did not clear registers");
   a_pin_hidden: assert property (chip_clear_gpio_o == 1'b0)
      else $error("clear pin shown as io");
   // reset itself must not disable this one
   a_power_up: assert property (disable iff (1'b0) !rstn_i |=> reg_o == POWERUP_HIGH)
      else $error("power-up value wrong");
endmodule

// File: dv/lcc_cluster_tb_top.sv
`timescale 1ns/1ns
module lcc_cluster_tb_top;
   logic clock_i, rstn_i, awv, wv, bready, arv, rready, pin, carry, sb, dn, inv, c;
   logic awr, wrdy, bv, arr, rv, zc, oc, cc, ch, z0, o1;
   logic [1:0] bresp, rresp;
   logic [7:0] aw, ar;
   logic [31:0] wd, rdata, seed, cv[6];
   logic [39:0] data, r40;
   logic [9:0] comb, rg, a, b, dv, ev[6], ep, ea;
   logic [10:0] s;
   logic [1:0] bq[$];
   logic [33:0] rq[$], mq[$];
   int errors = 0, tests_run = 0;
   lcc_cluster #(.POWERUP_HIGH(10'h2A5)) DUT (.clock_i(clock_i), .rstn_i(rstn_i), .s_axi_awaddr_i(aw),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bready), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready),
      .data_i(data), .zero_chain_carry_in_i(zc), .one_chain_carry_in_i(oc), .cluster_carry_in_i(cc),
      .reg_chain_i(ch), .lut_chain_i(ch), .chip_wide_clear_n_i(pin), .comb_o(comb), .reg_o(rg),
      .zero_chain_carry_out_o(z0), .one_chain_carry_out_o(o1), .cluster_carry_out_o(), .reg_chain_o(),
      .lut_chain_o(), .chip_clear_gpio_o());
   lcc_prev_cluster PREV (.clock_i(clock_i), .carry_i(carry), .zero_chain_o(zc), .one_chain_o(oc),
      .cluster_o(cc), .chain_o(ch));
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   // one nibble per cell: fourth data, operand b, operand a, count enable
   function automatic logic [39:0] pk(input logic [9:0] a, b, d);
      for (int i = 0; i < 10; i++) pk[4*i +: 4] = {d[i], b[i], a[i], 1'b1};
   endfunction
   task automatic conclude();
      if (errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp_b(input logic [1:0] e, input logic [1:0] v);
      tests_run++;
      if (v !== e) begin
         errors++;
         $display("CHECK FAILED bresp exp %h got %h", e, v);
      end
   endtask
   task automatic cmp_r(input logic [33:0] e, input logic [33:0] v, input logic [33:0] m);
      tests_run++;
      if ((v & m) !== (e & m)) begin
         errors++;
         $display("CHECK FAILED read exp %h got %h", e & m, v & m);
      end
   endtask
   // each channel is released on the edge that takes it; bready held until bvalid seen
   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] e);
      logic ta, tw, db;
      @(posedge clock_i);
      bq.push_back(e);
      aw <= ad; wd <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1; db = 1'b0;
      for (int n = 0; n < 50 && !db; n++) begin
         @(negedge clock_i); ta = awr & awv; tw = wrdy & wv; db = bv;
         @(posedge clock_i); if (ta) awv <= 1'b0; if (tw) wv <= 1'b0; if (db) bready <= 1'b0;
      end
      if (!db) begin errors++; conclude(); end
   endtask
   task automatic rd(input logic [7:0] ad, input logic [33:0] e, input logic [33:0] m);
      logic t, d;
      @(posedge clock_i);
      rq.push_back(e); mq.push_back(m);
      ar <= ad; arv <= 1'b1; rready <= 1'b1; d = 1'b0;
      for (int n = 0; n < 50 && !d; n++) begin
         @(negedge clock_i); t = arr & arv; d = rv;
         @(posedge clock_i); if (t) arv <= 1'b0; if (d) rready <= 1'b0;
      end
      if (!d) begin errors++; conclude(); end
   endtask
   // results are matched against the oldest note when the handshake completes
   always @(negedge clock_i) begin
      if (bv === 1'b1 && bready === 1'b1) cmp_b(bq.pop_front(), bresp);
      if (rv === 1'b1 && rready === 1'b1) cmp_r(rq.pop_front(), {rresp, rdata}, mq.pop_front());
   end
   initial begin
      {rstn_i, awv, wv, bready, arv, rready, carry, aw, ar, wd, data} = '0;
      pin = 1'b1; seed = 32'hED820509;
      @(posedge clock_i); @(negedge clock_i);
      cmp_r(34'h2A5, {24'h0, rg}, 34'h3FF);
      repeat (7) @(posedge clock_i);
      rstn_i <= 1'b1;
      rd(lcc_pkg::CTRL_OFF, 34'h18, '1);
      rd(lcc_pkg::CFG_BASE + 8'h24, 34'h0, '1);
      wr(8'h3C, 32'h1, 2'h2);
      rd(8'h3C, {2'h2, 32'h0}, '1);
      for (int i = 0; i < 10; i++) wr(lcc_pkg::CFG_BASE + 8'(4*i), 32'h10000, 2'h0);
      // add, subtract by select, count down by data, both, then carry from the cluster below
      for (int m = 0; m < 5; m++) begin
         seed = xs(seed); a = seed[9:0]; b = seed[19:10]; c = seed[20] & (m == 4);
         sb = (m == 1 || m == 3); dn = (m == 2 || m == 3); inv = sb ^ dn;
         carry <= c; data <= pk(a, b, {10{dn}});
         s = {1'b0, a} + {1'b0, inv ? ~b : b} + {10'h0, inv | c};
         wr(lcc_pkg::CTRL_OFF, {29'h3, sb, 2'h0}, 2'h0);
         wr(lcc_pkg::CFG_BASE, {10'h0, m < 4, 4'h0, 1'b1, 16'h0}, 2'h0);
         rd(lcc_pkg::COMB_OFF, {24'h0, s[9:0]}, '1);
         rd(lcc_pkg::STAT_OFF, {17'h1, s[10], 6'h0, s[9:0]}, '1);
         if (m < 4) cmp_r({32'h0, s[10], s[10]}, {32'h0, z0, o1}, 34'h3);
      end
      seed = xs(seed); dv = seed[9:0]; data <= pk(a, b, dv);
      cv = '{32'h19, 32'h98, 32'h198, 32'h10, 32'h1B8, 32'h1A};
      ev = '{10'h0, dv, 10'h3FF, 10'h3FF, 10'h0, dv};
      foreach (cv[k]) begin
         wr(lcc_pkg::CTRL_OFF, cv[k], 2'h0);
         rd(lcc_pkg::STAT_OFF, {24'h0, ev[k]}, 34'h3FF);
      end
      pin <= 1'b0;
      repeat (4) @(posedge clock_i);
      rd(lcc_pkg::STAT_OFF, 34'h0, 34'h203FF);
      pin <= 1'b1;
      // parity lut on the output, operand a packed into the register
      seed = xs(seed); r40 = {seed, seed[31:24] ^ 8'h5A}; data <= r40;
      for (int i = 0; i < 10; i++) begin
         ep[i] = ^r40[4*i +: 4];
         ea[i] = r40[4*i+1];
      end
      wr(lcc_pkg::CTRL_OFF, 32'h18, 2'h0);
      for (int i = 0; i < 10; i++) wr(lcc_pkg::CFG_BASE + 8'(4*i), 32'h86996, 2'h0);
      rd(lcc_pkg::COMB_OFF, {24'h0, ep}, '1);
      rd(lcc_pkg::STAT_OFF, {24'h0, ea}, 34'h3FF);
      repeat (2) @(posedge clock_i);
      conclude();
   end
endmodule
bind lcc_cluster lcc_cluster_props #(.POWERUP_HIGH(POWERUP_HIGH)) CHK (.clock_i(clock_i), .rstn_i(rstn_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
   .chip_wide_clear_n_i(chip_wide_clear_n_i), .comb_o(comb_o), .reg_o(reg_o), .reg_chain_o(reg_chain_o),
   .lut_chain_o(lut_chain_o), .chip_clear_gpio_o(chip_clear_gpio_o));

// File: dv/lcc_prev_cluster.sv
`timescale 1ns/1ns
module lcc_prev_cluster (
   input  wire logic clock_i,      // cluster clock
   input  wire logic carry_i,      // true carry below
   output logic      zero_chain_o, // chain assuming 0
   output logic      one_chain_o,  // chain assuming 1
   output logic      cluster_o,    // resolved carry
   output logic      chain_o       // lut and reg chain
);
   // lower cluster ends with both assumptions; its resolved carry picks one
   assign zero_chain_o = 1'b0;
   assign one_chain_o  = 1'b1;
   assign cluster_o    = carry_i;
   // chain lines toggle so a stale value never passes
   initial chain_o = 1'b0;
   always @(posedge clock_i) chain_o <= ~chain_o;
endmodule

// File: rtl/lcc_cluster.sv
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ns
// Function
// - each cell runs either general logic mode or dynamic arithmetic mode.
// - a cell takes four data inputs, two chain carries, cluster carry, register chain.
// - register clock, enable, clears, load controls come from cluster-wide signals.
// - add/subtract select acts only on cells in arithmetic mode.
// - general mode feeds a four-input lut; input 3 is data or carry.
// - lut chain passes the combinational output onward; register packing allowed.
// - asynchronous load data comes from the fourth data input.
// - arithmetic mode precomputes sums and carry-outs for carry zero and one.
// - cluster carry picks a chain; that chain's carry picks the sum.
// - each chain carry-in selects its own carry-out, forwarded upward.
// - arithmetic mode gives registered and unregistered results together.
// - count enable and up/down come from local data inputs in arithmetic mode.
// - synchronous clear and load act on every register of the cluster whose clock enable is high.
// - add/subtract select drives carry-in only at the chain's first cell.
// - a carry chain may begin at any cell of the cluster.
// - cluster carry is regenerated after the fifth and tenth cells only.
// - final carry-out can be routed out through a cell output.
// - chains longer than a cluster continue to the neighbour in the same row.
// - preset is an async load of one; clear beats preset/load.
// - a cluster offers two clears and one preset signal.
// - enabled chip-wide clear resets all and overrides; else pin is plain input.
// - registers power up low unless individually set to power up high.
// - subtraction or count-down, but not both, inverts operand b and forces chain carry-in to one.

module lcc_cluster #(
   parameter int                          CELLS         = lcc_pkg::CELLS,
   parameter int                          SEG           = lcc_pkg::SEG,
   parameter logic [lcc_pkg::CELLS-1:0]   POWERUP_HIGH  = '0,
   parameter logic                        CHIP_CLEAR_EN = 1'b1
) (
   input  wire logic                       clock_i,                   // 10 MHz clock
   input  wire logic                       rstn_i,                    // sync reset, active low
   input  wire logic [lcc_pkg::ADDR_W-1:0] s_axi_awaddr_i,            // write address
   input  wire logic                       s_axi_awvalid_i,
   output logic                            s_axi_awready_o,
   input  wire logic [31:0]                s_axi_wdata_i,             // write data
   input  wire logic [3:0]                 s_axi_wstrb_i,
   input  wire logic                       s_axi_wvalid_i,
   output logic                            s_axi_wready_o,
   output logic [1:0]                      s_axi_bresp_o,             // write response
   output logic                            s_axi_bvalid_o,
   input  wire logic                       s_axi_bready_i,
   input  wire logic [lcc_pkg::ADDR_W-1:0] s_axi_araddr_i,            // read address
   input  wire logic                       s_axi_arvalid_i,
   output logic                            s_axi_arready_o,
   output logic [31:0]                     s_axi_rdata_o,             // read data
   output logic [1:0]                      s_axi_rresp_o,
   output logic                            s_axi_rvalid_o,
   input  wire logic                       s_axi_rready_i,
   input  wire logic [4*CELLS-1:0]         data_i,                    // four data inputs per cell
   input  wire logic                       zero_chain_carry_in_i,     // from previous cluster
   input  wire logic                       one_chain_carry_in_i,      // from previous cluster
   input  wire logic                       cluster_carry_in_i,        // from previous cluster
   input  wire logic                       reg_chain_i,               // register chain in
   input  wire logic                       lut_chain_i,               // lut chain in
   input  wire logic                       chip_wide_clear_n_i,       // pin, async
   output logic [CELLS-1:0]                comb_o,                    // unregistered results
   output logic [CELLS-1:0]                reg_o,                     // registered results
   output logic                            zero_chain_carry_out_o,    // to next cluster
   output logic                            one_chain_carry_out_o,     // to next cluster
   output logic                            cluster_carry_out_o,       // to next cluster
   output logic                            reg_chain_o,               // register chain out
   output logic                            lut_chain_o,               // lut chain out
   output logic                            chip_clear_gpio_o          // pin level when not a clear
);

   localparam int NSEG = CELLS / SEG;
   localparam int AW   = lcc_pkg::ADDR_W;

   typedef struct packed {
      lcc_pkg::lcc_ctrl_t                ctrl;
      lcc_pkg::lcc_cfg_t [CELLS-1:0]     cfg;
      logic [CELLS-1:0]                  cell_q;
      logic                              pin_s1;
      logic                              pin_s2;
      logic                              aw_got;
      logic                              w_got;
      logic [AW-1:0]                     awaddr;
      logic [31:0]                       wdata;
      logic [3:0]                        wstrb;
      logic                              bvalid;
      logic [1:0]                        bresp;
      logic                              rvalid;
      logic [1:0]                        rresp;
      logic [31:0]                       rdata;
   } lcc_state_t;

   lcc_state_t st;
   lcc_state_t next_st;

   logic [CELLS-1:0] ci0;                     // incoming zero-chain carry
   logic [CELLS-1:0] ci1;                     // incoming one-chain carry
   logic [CELLS-1:0] co0;
   logic [CELLS-1:0] co1;
   logic [CELLS-1:0] selc;                    // carry chosen by segment carry
   logic [CELLS-1:0] comb;
   logic [CELLS-1:0] qnext;
   logic [NSEG:0]    seg_c;
   logic             chip_clr;

   ////////////////////////////////////////////////////////////////////////
   // carry segments: only segment ends sit on the long carry path
   assign seg_c[0] = cluster_carry_in_i;

   for (genvar k = 0; k < NSEG; k++) begin : g_seg
      assign seg_c[k+1] = seg_c[k] ? co1[(k+1)*SEG-1] : co0[(k+1)*SEG-1];
   end

   // chip-wide clear only counts once it has passed the synchroniser
   assign chip_clr = CHIP_CLEAR_EN & ~st.pin_s2;

   ////////////////////////////////////////////////////////////////////////
   // per-cell datapath
   for (genvar i = 0; i < CELLS; i++) begin : g_cell
      lcc_pkg::lcc_cfg_t c;
      logic [3:0] d;
      logic       inv;
      logic       pc0;
      logic       pc1;
      logic       prev_comb;
      logic       prev_q;
      logic       a;
      logic       b;
      logic       s0;
      logic       s1;
      logic       g0;
      logic       g1;
      logic       sum;
      logic       in0;
      logic       in3;
      logic       lut;
      logic       dsrc;
      logic       clr;
      logic       ce;

      assign c = st.cfg[i];
      assign d = data_i[4*i +: 4];

      // neighbours: first cell reaches into the previous cluster of the row
      if (i == 0) begin : g_first
         assign pc0       = zero_chain_carry_in_i;
         assign pc1       = one_chain_carry_in_i;
         assign prev_comb = lut_chain_i;
         assign prev_q    = reg_chain_i;
      end else begin : g_next
         assign pc0       = co0[i-1];
         assign pc1       = co1[i-1];
         assign prev_comb = comb[i-1];
         assign prev_q    = st.cell_q[i-1];
      end

      // operand b inverted when exactly one of subtract and count-down is set, arithmetic mode only
      assign inv = c.arith & (st.ctrl.sub ^ d[3]);

      // a chain may start anywhere; its start cell gets the forced carry
      assign ci0[i] = c.chain_start ? inv : pc0;
      assign ci1[i] = c.chain_start ? inv : pc1;

      // four two-input functions: two sums, two carry-outs
      assign a  = d[1];
      assign b  = d[2] ^ inv;
      assign s0 = a ^ b;
      assign s1 = ~(a ^ b);
      assign g0 = a & b;
      assign g1 = a | b;

      // each chain carry chooses its own carry-out
      assign co0[i] = ci0[i] ? g1 : g0;
      assign co1[i] = ci1[i] ? g1 : g0;

      // segment carry picks the chain, the chain picks the sum
      assign selc[i] = seg_c[i/SEG] ? ci1[i] : ci0[i];
      assign sum     = selc[i] ? s1 : s0;

      // general mode lookup table
      assign in0 = c.lut_chain ? prev_comb : d[0];
      assign in3 = c.d3_carry ? selc[i] : d[3];
      assign lut = c.mask[{in3, d[2], d[1], in0}];

      // mode decides what reaches the unregistered output
      always_comb begin
         if (c.carry_tap) begin
            comb[i] = selc[i];
         end else if (c.arith) begin
            comb[i] = sum;
         end else begin
            comb[i] = lut;
         end
      end

      // register data: packing lets the register serve unrelated logic
      always_comb begin
         if (c.arith) begin
            dsrc = d[0] ? sum : st.cell_q[i];
         end else begin
            case (c.reg_src)
               lcc_pkg::SRC_LUT: begin
                  dsrc = lut;
               end
               lcc_pkg::SRC_DATA: begin
                  dsrc = d[1];
               end
               lcc_pkg::SRC_CHAIN: begin
                  dsrc = prev_q;
               end
               default: begin
                  dsrc = st.cell_q[i];
               end
            endcase
         end
      end

      // two clears and two enables shared by the cluster
      assign clr = c.clr_sel ? st.ctrl.aclr1 : st.ctrl.aclr0;
      assign ce  = c.ena_sel ? st.ctrl.ce1 : st.ctrl.ce0;

      // register priority: chip clear, clear, preset/load, enable, sync
      always_comb begin
         if (chip_clr) begin
            qnext[i] = 1'b0;
         end else if (clr) begin
            qnext[i] = 1'b0;
         end else if (st.ctrl.aload) begin
            qnext[i] = st.ctrl.aload_preset ? 1'b1 : d[3];
         end else if (!ce) begin
            qnext[i] = st.cell_q[i];
         end else if (st.ctrl.sclr) begin
            qnext[i] = 1'b0;
         end else if (st.ctrl.sload) begin
            qnext[i] = d[3];
         end else begin
            qnext[i] = dsrc;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus handshakes: one write and one read outstanding
   logic          aw_hs;
   logic          w_hs;
   logic          ar_hs;
   logic          do_wr;
   logic [AW-1:0] waddr;
   logic [31:0]   wd;
   logic [3:0]    ws;

   assign s_axi_awready_o = ~st.aw_got & ~st.bvalid;
   assign s_axi_wready_o  = ~st.w_got & ~st.bvalid;
   assign s_axi_arready_o = ~st.rvalid;
   assign aw_hs = s_axi_awvalid_i & s_axi_awready_o;
   assign w_hs  = s_axi_wvalid_i & s_axi_wready_o;
   assign ar_hs = s_axi_arvalid_i & s_axi_arready_o;
   assign do_wr = (st.aw_got | aw_hs) & (st.w_got | w_hs) & ~st.bvalid;
   assign waddr = st.aw_got ? st.awaddr : s_axi_awaddr_i;
   assign wd    = st.w_got ? st.wdata : s_axi_wdata_i;
   assign ws    = st.w_got ? st.wstrb : s_axi_wstrb_i;

   // byte-lane merge for partial writes
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int n = 0; n < 4; n++) begin
         if (strb[n]) begin
            r[8*n +: 8] = new_v[8*n +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_st = st;
      // pin synchroniser: only the second stage is read
      next_st.pin_s1 = chip_wide_clear_n_i;
      next_st.pin_s2 = st.pin_s1;
      next_st.cell_q = qnext;

      // write channel capture
      if (aw_hs && !do_wr) begin
         next_st.aw_got = 1'b1;
         next_st.awaddr = s_axi_awaddr_i;
      end
      if (w_hs && !do_wr) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata_i;
         next_st.wstrb = s_axi_wstrb_i;
      end
      if (st.bvalid && s_axi_bready_i) begin
         next_st.bvalid = 1'b0;
      end

      // write decode; status words ignore writes, holes answer an error
      if (do_wr) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = lcc_pkg::RESP_SLVERR;
         if (waddr == lcc_pkg::CTRL_OFF) begin
            next_st.ctrl  = merge_bytes(st.ctrl, wd, ws);
            next_st.bresp = lcc_pkg::RESP_OKAY;
         end
         if (waddr == lcc_pkg::STAT_OFF || waddr == lcc_pkg::COMB_OFF) begin
            next_st.bresp = lcc_pkg::RESP_OKAY;
         end
         for (int j = 0; j < CELLS; j++) begin
            if (waddr == AW'(lcc_pkg::CFG_BASE + 4*j)) begin
               next_st.cfg[j] = merge_bytes(st.cfg[j], wd, ws);
               next_st.bresp  = lcc_pkg::RESP_OKAY;
            end
         end
      end

      // read path: data held in flops until taken
      if (st.rvalid && s_axi_rready_i) begin
         next_st.rvalid = 1'b0;
      end
      if (ar_hs) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = '0;
         next_st.rresp  = lcc_pkg::RESP_SLVERR;
         if (s_axi_araddr_i == lcc_pkg::CTRL_OFF) begin
            next_st.rdata = st.ctrl;
            next_st.rresp = lcc_pkg::RESP_OKAY;
         end
         if (s_axi_araddr_i == lcc_pkg::STAT_OFF) begin
            next_st.rdata[CELLS-1:0]          = st.cell_q;
            next_st.rdata[lcc_pkg::STAT_CARRY] = seg_c[NSEG];
            next_st.rdata[lcc_pkg::STAT_PIN]   = st.pin_s2;
            next_st.rresp = lcc_pkg::RESP_OKAY;
         end
         if (s_axi_araddr_i == lcc_pkg::COMB_OFF) begin
            next_st.rdata[CELLS-1:0] = comb;
            next_st.rresp = lcc_pkg::RESP_OKAY;
         end
         for (int j = 0; j < CELLS; j++) begin
            if (s_axi_araddr_i == AW'(lcc_pkg::CFG_BASE + 4*j)) begin
               next_st.rdata = st.cfg[j];
               next_st.rresp = lcc_pkg::RESP_OKAY;
            end
         end
      end

      // reset: registers take their power-up level
      if (!rstn_i) begin
         next_st        = '0;
         next_st.ctrl   = lcc_pkg::CTRL_RST;
         next_st.pin_s1 = lcc_pkg::PIN_RST;
         next_st.pin_s2 = lcc_pkg::PIN_RST;
         next_st.cell_q = POWERUP_HIGH[CELLS-1:0];
         for (int j = 0; j < CELLS; j++) begin
            next_st.cfg[j] = lcc_pkg::CFG_RST;
         end
      end
   end

   // single state register
   always_ff @(posedge clock_i) begin
      st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs; comb_o is the cell's lut, sum or carry result itself, so it cannot be a flop
   assign comb_o                 = comb;
   assign reg_o                  = st.cell_q;
   assign lut_chain_o            = comb[CELLS-1];
   assign reg_chain_o            = st.cell_q[CELLS-1];
   assign zero_chain_carry_out_o = co0[CELLS-1];
   assign one_chain_carry_out_o  = co1[CELLS-1];
   assign cluster_carry_out_o    = seg_c[NSEG];
   assign chip_clear_gpio_o      = CHIP_CLEAR_EN ? 1'b0 : st.pin_s2;
   assign s_axi_bvalid_o         = st.bvalid;
   assign s_axi_bresp_o          = st.bresp;
   assign s_axi_rvalid_o         = st.rvalid;
   assign s_axi_rresp_o          = st.rresp;
   assign s_axi_rdata_o          = st.rdata;

endmodule

// File: rtl/lcc_pkg.sv
package lcc_pkg;
   // cluster geometry
   localparam int CELLS = 10;                 // cells per cluster
   localparam int SEG   = 5;                  // cells per carry segment
   localparam int ADDR_W = 8;                 // register byte address width

   // register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam logic [7:0] COMB_OFF = 8'h08;
   localparam logic [7:0] CFG_BASE = 8'h40;   // one word per cell

   // status field positions
   localparam int STAT_CARRY = 16;
   localparam int STAT_PIN   = 17;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register source of a cell in general mode
   typedef enum logic [1:0] {
      SRC_LUT,
      SRC_DATA,
      SRC_CHAIN,
      SRC_HOLD
   } lcc_src_t;

   // cluster-wide register controls
   typedef struct packed {
      logic [22:0] pad;
      logic        aload_preset;              // async load drives a one
      logic        aload;                     // async preset/load
      logic        aclr1;
      logic        aclr0;
      logic        ce1;
      logic        ce0;
      logic        sub;                       // add/subtract select
      logic        sload;
      logic        sclr;
   } lcc_ctrl_t;

   // per-cell configuration word
   typedef struct packed {
      logic [6:0]  pad;
      logic        ena_sel;                   // clock enable 1 instead of 0
      logic        clr_sel;                   // clear 1 instead of 0
      logic        carry_tap;                 // output the selected carry
      logic        chain_start;               // first cell of a carry chain
      lcc_src_t    reg_src;
      logic        lut_chain;                 // lut input 0 from previous cell
      logic        d3_carry;                  // lut input 3 from carry
      logic        arith;                     // dynamic arithmetic mode
      logic [15:0] mask;                      // lut truth table
   } lcc_cfg_t;

   // values after reset
   localparam logic [31:0] CTRL_RST = 32'h00000018;
   localparam logic [31:0] CFG_RST  = 32'h00000000;
   localparam logic        PIN_RST  = 1'b1;
endpackage
